/* rtl/logic_cell_gate2_input_select.sv */
// gate-2 input selection stage of a configurable logic cell
// assumes data inputs come from same-clock logic and the bus master
// keeps strobes one cycle wide and never raises both at once
//
// Notes on behaviour
// - select bit 7 gates true input 4, bit 6 inverted input 4 into the term
// - select bit 5 gates true input 3, bit 4 inverted input 3 into the term
// - select bit 3 gates true input 2, bit 2 inverted input 2 into the term
// - select bit 1 gates true input 1, bit 0 inverted input 1 into the term
`timescale 1ns/1ps

module logic_cell_gate2_input_select (
   input wire logic sys_clk,
   input wire logic reset,
   input wire gate2_sel_pkg::reg_addr_t reg_addr,
   input wire gate2_sel_pkg::reg_data_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output gate2_sel_pkg::reg_data_t reg_rdata,
   input wire gate2_sel_pkg::data_in_t data_in,
   output logic gate2_term
);
   import gate2_sel_pkg::*;

   // ==========================================
   // address decode
   logic sel_hit;
   logic sel_write;
   logic sel_read;

   always_comb begin
      sel_hit = (reg_addr == SEL_OFFSET);
      sel_write = reg_write && sel_hit;
      sel_read = reg_read && sel_hit;
   end

   // ==========================================
   // select register storage
   gate2_sel_t sel;
   reg_data_t sel_raw;

   sel_store #(
      .W(DATA_W)
   ) u_sel_store (
      .sys_clk(sys_clk),
      .wr_en(sel_write),
      .wr_data(reg_wdata),
      .stored(sel_raw)
   );

   assign sel = gate2_sel_t'(sel_raw);

   // ==========================================
   // read data, one cycle after the read strobe
   reg_data_t rdata_q;
   reg_data_t rdata_d;

   always_comb begin
      rdata_d = RDATA_RESET;
      if (reg_read) begin
         if (sel_hit) begin
            rdata_d = sel_raw;
         end else begin
            rdata_d = UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdata_q <= RDATA_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ==========================================
   // polarity gating per data input
   logic in4_contrib;
   logic in3_contrib;
   logic in2_contrib;
   logic in1_contrib;

   polarity_gate #(
      .W(1)
   ) u_gate_in4 (
      .data_true(data_in.data_in4_true),
      .true_en(sel.g2_in4_true_en),
      .inv_en(sel.g2_in4_inv_en),
      .contrib(in4_contrib)
   );

   polarity_gate #(
      .W(1)
   ) u_gate_in3 (
      .data_true(data_in.data_in3_true),
      .true_en(sel.g2_in3_true_en),
      .inv_en(sel.g2_in3_inv_en),
      .contrib(in3_contrib)
   );

   polarity_gate #(
      .W(1)
   ) u_gate_in2 (
      .data_true(data_in.data_in2_true),
      .true_en(sel.g2_in2_true_en),
      .inv_en(sel.g2_in2_inv_en),
      .contrib(in2_contrib)
   );

   polarity_gate #(
      .W(1)
   ) u_gate_in1 (
      .data_true(data_in.data_in1_true),
      .true_en(sel.g2_in1_true_en),
      .inv_en(sel.g2_in1_inv_en),
      .contrib(in1_contrib)
   );

   // ==========================================
   // gate-2 term, or of every enabled polarity
   logic term_q;
   logic term_d;

   always_comb begin
      term_d = in4_contrib | in3_contrib | in2_contrib | in1_contrib;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         term_q <= TERM_RESET;
      end else begin
         term_q <= term_d;
      end
   end

   assign gate2_term = term_q;

   // ==========================================
   // helper views for checking
   logic [3:0] data_vec;
   logic [3:0] true_en_vec;
   logic [3:0] inv_en_vec;
   logic ref_term;
   logic sel_one_hot;

   always_comb begin
      data_vec = {data_in.data_in4_true, data_in.data_in3_true,
                  data_in.data_in2_true, data_in.data_in1_true};
      true_en_vec = {sel_raw[POS_IN4_TRUE], sel_raw[POS_IN3_TRUE],
                     sel_raw[POS_IN2_TRUE], sel_raw[POS_IN1_TRUE]};
      inv_en_vec = {sel_raw[POS_IN4_INV], sel_raw[POS_IN3_INV],
                    sel_raw[POS_IN2_INV], sel_raw[POS_IN1_INV]};
      ref_term = |((true_en_vec & data_vec) | (inv_en_vec & ~data_vec));
      sel_one_hot = $onehot(sel_raw);
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   in4_true_route_a: assert property (sel.g2_in4_true_en && data_in.data_in4_true |=> gate2_term)
      else $error("true input 4 enabled and high but term low");
   in4_inv_route_a: assert property (sel.g2_in4_inv_en && !data_in.data_in4_true |=> gate2_term)
      else $error("inverted input 4 enabled and low but term low");

   in3_true_route_a: assert property (sel.g2_in3_true_en && data_in.data_in3_true |=> gate2_term)
      else $error("true input 3 enabled and high but term low");
   in3_inv_route_a: assert property (sel.g2_in3_inv_en && !data_in.data_in3_true |=> gate2_term)
      else $error("inverted input 3 enabled and low but term low");

   in2_true_route_a: assert property (sel.g2_in2_true_en && data_in.data_in2_true |=> gate2_term)
      else $error("true input 2 enabled and high but term low");
   in2_inv_route_a: assert property (sel.g2_in2_inv_en && !data_in.data_in2_true |=> gate2_term)
      else $error("inverted input 2 enabled and low but term low");

   in1_true_route_a: assert property (sel.g2_in1_true_en && data_in.data_in1_true |=> gate2_term)
      else $error("true input 1 enabled and high but term low");
   in1_inv_route_a: assert property (sel.g2_in1_inv_en && !data_in.data_in1_true |=> gate2_term)
      else $error("inverted input 1 enabled and low but term low");

   term_excluded_a: assert property (
      ((true_en_vec & data_vec) == 4'h0) && ((inv_en_vec & ~data_vec) == 4'h0) |=> !gate2_term)
      else $error("term high with no enabled polarity active");

   sel_write_a: assert property (sel_write |=> sel_raw == $past(reg_wdata))
      else $error("select register did not take written value");

   sel_hold_a: assert property (!sel_write |=> $stable(sel_raw))
      else $error("select register changed without a write");

   sel_readback_a: assert property (sel_read |=> reg_rdata == $past(sel_raw))
      else $error("read data differs from select register");

   write_then_read_a: assert property (sel_write ##1 sel_read |=> reg_rdata == $past(reg_wdata, 2))
      else $error("back-to-back read missed the written value");

   unmapped_read_a: assert property (reg_read && !sel_hit |=> reg_rdata == UNMAPPED_READ)
      else $error("unmapped read returned nonzero data");

   idle_rdata_a: assert property (!reg_read |=> reg_rdata == RDATA_RESET)
      else $error("read data not cleared outside a read");

   term_included_a: assert property (ref_term |=> gate2_term)
      else $error("an enabled polarity is active but term low");

   all_clear_a: assert property (sel_raw == 8'h00 |=> !gate2_term)
      else $error("term high with every select bit cleared");

   stray_write_a: assert property (reg_write && !sel_hit |=> $stable(sel_raw))
      else $error("write to another address changed the select register");

   read_no_write_a: assert property (reg_read && !reg_write |=> $stable(sel_raw))
      else $error("read changed the select register");

   read_pulse_a: assert property (reg_read ##1 !reg_read |=> reg_rdata == RDATA_RESET)
      else $error("read data stood longer than one cycle");

   // ==========================================
   // reset behaviour of the outputs
   rdata_in_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0)
      reset && $past(reset) |-> reg_rdata == RDATA_RESET)
      else $error("read data not cleared while reset is held");
   term_in_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0)
      reset && $past(reset) |-> gate2_term == TERM_RESET)
      else $error("term not cleared while reset is held");

   // ==========================================
   // per-input contribution, both polarities
   in4_true_incl_a: assert property (sel.g2_in4_true_en && data_in.data_in4_true |-> in4_contrib)
      else $error("true input 4 enabled and high but no contribution");
   in4_inv_incl_a: assert property (sel.g2_in4_inv_en && !data_in.data_in4_true |-> in4_contrib)
      else $error("inverted input 4 enabled and low but no contribution");
   in4_true_excl_a: assert property (!sel.g2_in4_true_en && data_in.data_in4_true |-> !in4_contrib)
      else $error("true input 4 cleared but high input contributes");
   in4_inv_excl_a: assert property (!sel.g2_in4_inv_en && !data_in.data_in4_true |-> !in4_contrib)
      else $error("inverted input 4 cleared but low input contributes");
   in4_both_pol_a: assert property (sel.g2_in4_true_en && sel.g2_in4_inv_en |-> in4_contrib)
      else $error("input 4 with both polarities enabled gives no contribution");

   in3_true_incl_a: assert property (sel.g2_in3_true_en && data_in.data_in3_true |-> in3_contrib)
      else $error("true input 3 enabled and high but no contribution");
   in3_inv_incl_a: assert property (sel.g2_in3_inv_en && !data_in.data_in3_true |-> in3_contrib)
      else $error("inverted input 3 enabled and low but no contribution");
   in3_true_excl_a: assert property (!sel.g2_in3_true_en && data_in.data_in3_true |-> !in3_contrib)
      else $error("true input 3 cleared but high input contributes");
   in3_inv_excl_a: assert property (!sel.g2_in3_inv_en && !data_in.data_in3_true |-> !in3_contrib)
      else $error("inverted input 3 cleared but low input contributes");
   in3_both_pol_a: assert property (sel.g2_in3_true_en && sel.g2_in3_inv_en |-> in3_contrib)
      else $error("input 3 with both polarities enabled gives no contribution");

   in2_true_incl_a: assert property (sel.g2_in2_true_en && data_in.data_in2_true |-> in2_contrib)
      else $error("true input 2 enabled and high but no contribution");
   in2_inv_incl_a: assert property (sel.g2_in2_inv_en && !data_in.data_in2_true |-> in2_contrib)
      else $error("inverted input 2 enabled and low but no contribution");
   in2_true_excl_a: assert property (!sel.g2_in2_true_en && data_in.data_in2_true |-> !in2_contrib)
      else $error("true input 2 cleared but high input contributes");
   in2_inv_excl_a: assert property (!sel.g2_in2_inv_en && !data_in.data_in2_true |-> !in2_contrib)
      else $error("inverted input 2 cleared but low input contributes");
   in2_both_pol_a: assert property (sel.g2_in2_true_en && sel.g2_in2_inv_en |-> in2_contrib)
      else $error("input 2 with both polarities enabled gives no contribution");

   in1_true_incl_a: assert property (sel.g2_in1_true_en && data_in.data_in1_true |-> in1_contrib)
      else $error("true input 1 enabled and high but no contribution");
   in1_inv_incl_a: assert property (sel.g2_in1_inv_en && !data_in.data_in1_true |-> in1_contrib)
      else $error("inverted input 1 enabled and low but no contribution");
   in1_true_excl_a: assert property (!sel.g2_in1_true_en && data_in.data_in1_true |-> !in1_contrib)
      else $error("true input 1 cleared but high input contributes");
   in1_inv_excl_a: assert property (!sel.g2_in1_inv_en && !data_in.data_in1_true |-> !in1_contrib)
      else $error("inverted input 1 cleared but low input contributes");
   in1_both_pol_a: assert property (sel.g2_in1_true_en && sel.g2_in1_inv_en |-> in1_contrib)
      else $error("input 1 with both polarities enabled gives no contribution");

   // ==========================================
   // single enabled polarity gates nothing else
   in4_true_only_a: assert property (sel_one_hot && true_en_vec[3] && !data_vec[3] |=> !gate2_term)
      else $error("only true input 4 enabled and low but term high");
   in4_inv_only_a: assert property (sel_one_hot && inv_en_vec[3] && data_vec[3] |=> !gate2_term)
      else $error("only inverted input 4 enabled and high but term high");

   in3_true_only_a: assert property (sel_one_hot && true_en_vec[2] && !data_vec[2] |=> !gate2_term)
      else $error("only true input 3 enabled and low but term high");
   in3_inv_only_a: assert property (sel_one_hot && inv_en_vec[2] && data_vec[2] |=> !gate2_term)
      else $error("only inverted input 3 enabled and high but term high");

   in2_true_only_a: assert property (sel_one_hot && true_en_vec[1] && !data_vec[1] |=> !gate2_term)
      else $error("only true input 2 enabled and low but term high");
   in2_inv_only_a: assert property (sel_one_hot && inv_en_vec[1] && data_vec[1] |=> !gate2_term)
      else $error("only inverted input 2 enabled and high but term high");

   in1_true_only_a: assert property (sel_one_hot && true_en_vec[0] && !data_vec[0] |=> !gate2_term)
      else $error("only true input 1 enabled and low but term high");
   in1_inv_only_a: assert property (sel_one_hot && inv_en_vec[0] && data_vec[0] |=> !gate2_term)
      else $error("only inverted input 1 enabled and high but term high");

   // ==========================================
   // covers
   all_off_c: cover property (sel_write && reg_wdata == 8'h00 ##1 !gate2_term);
   inv_only_c: cover property (sel_raw == 8'h55 ##1 gate2_term);
   both_pol_c: cover property (sel.g2_in4_true_en && sel.g2_in4_inv_en ##1 gate2_term);
   write_read_c: cover property (sel_write ##1 sel_read ##1 reg_rdata != 8'h00);
   reset_then_read_c: cover property ($fell(reset) ##1 sel_read);

endmodule : logic_cell_gate2_input_select

/* rtl/gate2_sel_pkg.sv */
// package for the gate-2 input selection stage of a logic cell
// assumes a single register clock; no timing figures apply to this block
package gate2_sel_pkg;

   // ==========================================
   // register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   typedef logic [ADDR_W-1:0] reg_addr_t;
   typedef logic [DATA_W-1:0] reg_data_t;

   localparam reg_addr_t SEL_OFFSET = 4'h0;
   localparam reg_data_t RDATA_RESET = 8'h00;
   localparam reg_data_t UNMAPPED_READ = 8'h00;
   localparam logic TERM_RESET = 1'b0;

   // ==========================================
   // select field positions
   localparam int POS_IN4_TRUE = 7;
   localparam int POS_IN4_INV = 6;
   localparam int POS_IN3_TRUE = 5;
   localparam int POS_IN3_INV = 4;
   localparam int POS_IN2_TRUE = 3;
   localparam int POS_IN2_INV = 2;
   localparam int POS_IN1_TRUE = 1;
   localparam int POS_IN1_INV = 0;

   // bit 7 first, bit 0 last
   typedef struct packed {
      logic g2_in4_true_en;
      logic g2_in4_inv_en;
      logic g2_in3_true_en;
      logic g2_in3_inv_en;
      logic g2_in2_true_en;
      logic g2_in2_inv_en;
      logic g2_in1_true_en;
      logic g2_in1_inv_en;
   } gate2_sel_t;

   // ==========================================
   // data inputs from the four data selectors
   typedef struct packed {
      logic data_in4_true;
      logic data_in3_true;
      logic data_in2_true;
      logic data_in1_true;
   } data_in_t;

endpackage : gate2_sel_pkg

/* rtl/polarity_gate.sv */
// one data input gated into a term in true and/or inverted polarity
// assumes data and enables are settled logic of the same clock
`timescale 1ns/1ps

module polarity_gate #(
   parameter int W = 1
) (
   input wire logic [W-1:0] data_true,
   input wire logic [W-1:0] true_en,
   input wire logic [W-1:0] inv_en,
   output logic [W-1:0] contrib
);

   logic [W-1:0] data_inverted;

   always_comb begin
      data_inverted = ~data_true;
      contrib = (true_en & data_true) | (inv_en & data_inverted);
   end

endmodule : polarity_gate

/* rtl/sel_store.sv */
// storage for a software select register
// holds no reset: contents are unknown at power-on, kept across resets
`timescale 1ns/1ps

module sel_store #(
   parameter int W = 8
) (
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   output logic [W-1:0] stored
);

   logic [W-1:0] store_q;
   logic [W-1:0] store_d;

   always_comb begin
      store_d = wr_en ? wr_data : store_q;
   end

   // deliberately no reset branch
   always_ff @(posedge sys_clk) begin
      store_q <= store_d;
   end

   assign stored = store_q;

endmodule : sel_store

/* tb/logic_cell_gate2_input_select_tb_top.sv */
// self-checking bench for the gate-2 input selection stage
// assumes the design package is compiled first; bench drives all ports
`timescale 1ns/1ps

module logic_cell_gate2_input_select_tb_top;
   import gate2_sel_pkg::*;

   // ==========================================
   // stimulus and observation
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   reg_addr_t reg_addr = 4'h0;
   reg_data_t reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   reg_data_t reg_rdata;
   data_in_t data_in = 4'h0;
   logic gate2_term;
   int fails = 0;
   int n_checks = 0;
   int cycles = 0;

   logic_cell_gate2_input_select u_dut (
      .sys_clk(sys_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .data_in(data_in),
      .gate2_term(gate2_term)
   );

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ==========================================
   // shared tasks
   task check(input reg_data_t seen, input reg_data_t exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task reg_wr(input reg_addr_t a, input reg_data_t d);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : reg_wr

   task reg_rd(input reg_addr_t a, input reg_data_t exp);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata, exp);
      @(posedge sys_clk);
      #1 check(reg_rdata, 8'h00);
   endtask : reg_rd

   // data applied, select written, term looked at two edges on
   task term_case(input reg_data_t s, input data_in_t d, input logic e);
      @(posedge sys_clk);
      data_in <= d;
      reg_wr(SEL_OFFSET, s);
      @(posedge sys_clk);
      #1 check({7'h00, gate2_term}, {7'h00, e});
   endtask : term_case

   task conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // ==========================================
   // scenarios
   task test_in4;
      term_case(8'h80, 4'h8, 1'b1);
      term_case(8'h80, 4'h7, 1'b0);
      term_case(8'h40, 4'h7, 1'b1);
      term_case(8'h40, 4'hF, 1'b0);
      term_case(8'hC0, 4'h0, 1'b1);
      term_case(8'hC0, 4'h8, 1'b1);
      term_case(8'h55, 4'hF, 1'b0);
      term_case(8'h55, 4'h7, 1'b1);
      $display("test in4 done");
   endtask : test_in4

   task test_in3;
      term_case(8'h20, 4'h4, 1'b1);
      term_case(8'h20, 4'hB, 1'b0);
      term_case(8'h10, 4'hB, 1'b1);
      term_case(8'h10, 4'hF, 1'b0);
      $display("test in3 done");
   endtask : test_in3

   task test_in2;
      term_case(8'h08, 4'h2, 1'b1);
      term_case(8'h08, 4'hD, 1'b0);
      term_case(8'h04, 4'hD, 1'b1);
      term_case(8'h04, 4'hF, 1'b0);
      $display("test in2 done");
   endtask : test_in2

   task test_in1;
      term_case(8'h02, 4'h1, 1'b1);
      term_case(8'h02, 4'hE, 1'b0);
      term_case(8'h01, 4'hE, 1'b1);
      term_case(8'h01, 4'hF, 1'b0);
      term_case(8'h03, 4'h0, 1'b1);
      term_case(8'h00, 4'hA, 1'b0);
      term_case(8'hAA, 4'h0, 1'b0);
      term_case(8'hAA, 4'h1, 1'b1);
      $display("test in1 done");
   endtask : test_in1

   task test_regs;
      reg_wr(SEL_OFFSET, 8'hA5);
      reg_rd(SEL_OFFSET, 8'hA5);
      reg_wr(4'h3, 8'h5A);
      reg_rd(SEL_OFFSET, 8'hA5);
      reg_rd(4'h3, UNMAPPED_READ);
      // write then read with no gap
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_wdata <= 8'h3C;
      reg_addr <= SEL_OFFSET;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata, 8'h3C);
      // mid-run reset keeps the select contents
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      #1 check({7'h00, gate2_term}, 8'h00);
      check(reg_rdata, RDATA_RESET);
      reg_rd(SEL_OFFSET, 8'h3C);
      $display("test regs done");
   endtask : test_regs

   // ==========================================
   // main sequence and hang guard
   initial begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      test_in4();
      test_in3();
      test_in2();
      test_in1();
      test_regs();
      conclude();
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         conclude();
      end
   end

endmodule : logic_cell_gate2_input_select_tb_top
